// *** hdl/clic_pkg.sv ***
// constants and types shared by the configuration loader and integrity block
// Functional notes
// - test port disabled by default; pins are GPIO
// - blank flash at power-up enables test port
// - default bus address at power-up enables test port
// - shorted/open address strap forces default address
// - bad firmware checksum: stay responsive, no run
// - bad config checksum loads factory defaults
// - config checksum failure asserts alert, status flag
// - error log checked against its checksum
// - each reset: recheck log, erase if bad
// - watchdog timeout triggers normal device reset
// - in reset: GPIO released, fast PWM low
// - parameters range-checked, out-of-range rejected
// - six check bits per 32-bit flash word
// - single-bit flash read errors corrected
// - after rewrite: old config, logging off
// - standard TAP protocol, no boundary scan
// - four test pins reusable as GPIO
// - flash image loadable over I2C or TAP
// - param writes hit RAM; store-all commits
package clic_pkg;
	localparam int CLK_MHZ = 25;
	localparam int DATA_W = 32;
	localparam int CHK_W = 6;
	localparam int CW_W = DATA_W + CHK_W;
	localparam int ADDR_W = 12;
	localparam int DEV_ADDR_W = 7;
	localparam int REGION_WORDS_DFLT = 16;
	localparam logic [ADDR_W-1:0] FW_BASE = 12'h000;
	localparam logic [ADDR_W-1:0] CFG_BASE = 12'h100;
	localparam logic [ADDR_W-1:0] LOG_BASE = 12'h200;
	localparam logic [DEV_ADDR_W-1:0] DFLT_DEV_ADDR = 7'h7e;
	localparam logic [7:0] ADDR_BIN_MULT = 8'h0c;
	localparam logic [DATA_W-1:0] BLANK_WORD = 32'hffffffff;
	localparam logic [DATA_W-1:0] CFG_DFLT_VAL = 32'h00000000;
	localparam logic [DATA_W-1:0] PARAM_MAX = 32'h0000ffff;
	localparam int WDT_TIMEOUT_US = 100000;
	localparam int WDT_CYCLES_DFLT = WDT_TIMEOUT_US * CLK_MHZ;
	localparam logic [7:0] SRST_HOLD_CYCLES = 8'h10;
	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
	localparam logic [IR_W-1:0] IR_PROG = 4'h8;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam int DR_PROG_W = ADDR_W + DATA_W;
	localparam int SHARED_PINS = 4;
	localparam int FAST_PULSE_WIDTH_PIN_PINS = 8;

	typedef enum logic [3:0] {B_CAPT, B_RD, B_ACC, B_DFLT, B_ERASE, B_EWAIT, B_RUN, B_STORE} clic_boot_type;
	typedef enum logic [3:0] {T_TLR, T_RTI, T_SDS, T_CDR, T_SDR, T_E1D, T_PDR, T_E2D, T_UDR,
		T_SIS, T_CIR, T_SIR, T_E1I, T_PIR, T_E2I, T_UIR} clic_tap_type;
endpackage

// *** hdl/clic_ecc.sv ***
// single-error-correcting check bit generator and corrector for flash words
module clic_ecc
#(
	parameter int DW = 32,
	parameter int CW = 6
)
(
	// word and stored check bits
	input wire logic [DW-1:0] data_in,
	input wire logic [CW-1:0] chk_in,
	// generated check bits, corrected word
	output logic [CW-1:0] chk_out,
	output logic [DW-1:0] fix_out,
	output logic err_out
);
	logic [CW-1:0] pos_a;
	logic [CW-1:0] pos_b;
	logic [CW-1:0] syn;

	// each data bit owns a non-power-of-two position; check bits are the xor of owned positions
	always_comb
	begin
		chk_out = '0;
		pos_a = CW'(2);
		for (int i = 0; i < DW; i++)
		begin
			pos_a = pos_a + CW'(1);
			if ((pos_a & (pos_a - CW'(1))) == '0)
				pos_a = pos_a + CW'(1);
			if (data_in[i])
				chk_out = chk_out ^ pos_a;
		end
	end

	assign syn = chk_out ^ chk_in;
	assign err_out = (syn != '0);

	// a syndrome equal to a power of two is a check-bit error; data passes untouched
	always_comb
	begin
		fix_out = data_in;
		pos_b = CW'(2);
		for (int i = 0; i < DW; i++)
		begin
			pos_b = pos_b + CW'(1);
			if ((pos_b & (pos_b - CW'(1))) == '0)
				pos_b = pos_b + CW'(1);
			if (syn == pos_b)
				fix_out[i] = ~data_in[i];
		end
	end
endmodule

// *** hdl/clic_top.sv ***
// power-up integrity checks, configuration loading, test port gating and flash writing
module clic_top
	import clic_pkg::*;
#(
	parameter int REGION_WORDS = REGION_WORDS_DFLT,
	parameter int WDT_CYCLES = WDT_CYCLES_DFLT
)
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// address straps, already binned
	input wire logic [3:0] addr_bin_hi_in,
	input wire logic [3:0] addr_bin_lo_in,
	input wire logic addr_fault_in,
	// data flash
	output logic flash_rd_out,
	output logic flash_wr_out,
	output logic flash_erase_out,
	output logic flash_erase_log_out,
	output logic [ADDR_W-1:0] flash_addr_out,
	output logic [CW_W-1:0] flash_wdata_out,
	input wire logic [CW_W-1:0] flash_rdata_in,
	input wire logic flash_busy_in,
	// host image load
	input wire logic flash_wp_in,
	input wire logic img_erase_in,
	input wire logic img_wr_in,
	input wire logic [ADDR_W-1:0] img_addr_in,
	input wire logic [DATA_W-1:0] img_data_in,
	output logic img_ready_out,
	// host parameters
	input wire logic param_wr_in,
	input wire logic [ADDR_W-1:0] param_idx_in,
	input wire logic [DATA_W-1:0] param_val_in,
	input wire logic [ADDR_W-1:0] param_rd_idx_in,
	output logic [DATA_W-1:0] param_rd_data_out,
	output logic param_reject_out,
	input wire logic store_all_in,
	input wire logic alert_clr_in,
	input wire logic wdt_kick_in,
	// status
	output logic boot_done_out,
	output logic fw_run_out,
	output logic cfg_default_out,
	output logic cfg_crc_err_out,
	output logic bus_alert_out_n,
	output logic log_corrupt_out,
	output logic log_en_out,
	output logic jtag_en_out,
	output logic ecc_fix_out,
	output logic in_reset_out,
	output logic [DEV_ADDR_W-1:0] dev_addr_out,
	// shared test/GPIO pins: 0 tck, 1 tms, 2 tdi, 3 tdo
	input wire logic [SHARED_PINS-1:0] shared_pin_in,
	input wire logic [SHARED_PINS-1:0] app_gpio_out_in,
	input wire logic [SHARED_PINS-1:0] app_gpio_oe_in,
	output logic [SHARED_PINS-1:0] shared_pin_out,
	output logic [SHARED_PINS-1:0] shared_pin_oe_out,
	// fast pwm pins
	input wire logic [FAST_PULSE_WIDTH_PIN_PINS-1:0] app_fast_pulse_width_pin_in,
	output logic [FAST_PULSE_WIDTH_PIN_PINS-1:0] fast_pulse_width_pin
);
	localparam logic [ADDR_W-1:0] LAST_IDX = ADDR_W'(REGION_WORDS);

	clic_boot_type state_r;
	clic_tap_type tap_r;
	clic_tap_type tap_nxt;
	logic [DATA_W-1:0] cfg_ram [REGION_WORDS];
	logic [1:0] region_r;
	logic [ADDR_W-1:0] idx_r;
	logic [DATA_W-1:0] sum_r;
	logic blank_r, fw_ok_r, cfg_ok_r, log_bad_r, pwrup_done_r, jtag_en_r, dirty_r, crc_err_r;
	logic [DEV_ADDR_W-1:0] dev_addr_r;
	logic [31:0] wdt_cnt_r;
	logic [7:0] srst_cnt_r;
	logic rst_hold_r;
	logic rd_r, wr_r, erase_r, erase_log_r, fix_r, reject_r;
	logic [ADDR_W-1:0] faddr_r;
	logic [CW_W-1:0] wdata_r;
	logic [DATA_W-1:0] rd_data_r;
	logic tck_q_r, tdo_r, tdo_oe_r, jtag_req_r;
	logic [IR_W-1:0] ir_r, ir_sh_r;
	logic [DR_PROG_W-1:0] dr_sh_r;

	// decode and selection
	logic [ADDR_W-1:0] base;
	logic last;
	logic [DATA_W-1:0] dec_data;
	logic dec_err;
	logic [CHK_W-1:0] enc_chk;
	logic [DEV_ADDR_W-1:0] strap_addr;
	logic run, can_write, store_go, jtag_go, img_go, erase_go, sum_ok;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic ram_we;
	logic [ADDR_W-1:0] ram_wa;
	logic [DATA_W-1:0] ram_wd;
	logic param_ok, wdt_fire, tck_rise, tck_fall, tms, tdi;
	logic [7:0] strap_sum;

	assign base = (region_r == 2'd0) ? FW_BASE : (region_r == 2'd1) ? CFG_BASE : LOG_BASE;
	assign last = (idx_r == LAST_IDX);
	assign sum_ok = (sum_r == dec_data);
	assign strap_sum = ADDR_BIN_MULT * {4'h0, addr_bin_hi_in} + {4'h0, addr_bin_lo_in};
	assign strap_addr = addr_fault_in ? DFLT_DEV_ADDR : strap_sum[DEV_ADDR_W-1:0];
	assign run = (state_r == B_RUN);
	// image, TAP and erase requests need protection off and an idle flash; a pending pulse counts as busy
	assign can_write = !flash_wp_in && !flash_busy_in && !wr_r && !erase_r;
	assign store_go = (state_r == B_STORE) && !flash_busy_in && !wr_r;
	assign jtag_go = run && jtag_req_r && jtag_en_r && can_write && !store_all_in;
	assign img_go = run && img_wr_in && img_ready_out;
	assign erase_go = run && img_erase_in && can_write && !jtag_go && !img_wr_in && !store_all_in;
	assign img_ready_out = run && can_write && !store_all_in && !(jtag_req_r && jtag_en_r);
	assign wr_addr = store_go ? CFG_BASE + idx_r : jtag_go ? dr_sh_r[DR_PROG_W-1:DATA_W] : img_addr_in;
	assign wr_data = store_go ? (last ? sum_r : cfg_ram[idx_r[$clog2(REGION_WORDS)-1:0]])
		: jtag_go ? dr_sh_r[DATA_W-1:0] : img_data_in;
	assign param_ok = (param_idx_in < LAST_IDX) && (param_val_in <= PARAM_MAX);

	// config RAM: boot load, default fill, or host parameter write
	assign ram_we = (state_r == B_ACC && region_r == 2'd1 && !last) || (state_r == B_DFLT)
		|| (run && param_wr_in && param_ok);
	assign ram_wa = run ? param_idx_in : idx_r;
	assign ram_wd = (state_r == B_DFLT) ? CFG_DFLT_VAL : run ? param_val_in : dec_data;

	clic_ecc #(.DW(DATA_W), .CW(CHK_W)) u_enc
	(
		.data_in(wr_data),
		.chk_in(6'h00),
		.chk_out(enc_chk),
		.fix_out(),
		.err_out()
	);

	clic_ecc #(.DW(DATA_W), .CW(CHK_W)) u_dec
	(
		.data_in(flash_rdata_in[DATA_W-1:0]),
		.chk_in(flash_rdata_in[CW_W-1:DATA_W]),
		.chk_out(),
		.fix_out(dec_data),
		.err_out(dec_err)
	);

	// watchdog and reset hold
	assign wdt_fire = run && fw_ok_r && (wdt_cnt_r == 32'(WDT_CYCLES - 1));

	always_ff @(posedge core_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			wdt_cnt_r <= '0;
			srst_cnt_r <= '0;
			rst_hold_r <= 1'b1;
		end
		else
		begin
			wdt_cnt_r <= (wdt_kick_in || !run || !fw_ok_r || wdt_fire) ? '0 : wdt_cnt_r + 32'h1;
			srst_cnt_r <= wdt_fire ? SRST_HOLD_CYCLES : (srst_cnt_r != '0) ? srst_cnt_r - 8'h01 : '0;
			rst_hold_r <= wdt_fire || (srst_cnt_r > 8'h01);
		end
	end

	// boot sequence: firmware, config, log; then run
	always_ff @(posedge core_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			state_r <= B_CAPT;
			region_r <= '0;
			idx_r <= '0;
			sum_r <= '0;
			blank_r <= 1'b1;
			fw_ok_r <= 1'b0;
			cfg_ok_r <= 1'b0;
			log_bad_r <= 1'b0;
			dirty_r <= 1'b0;
			crc_err_r <= 1'b0;
			pwrup_done_r <= 1'b0;
			jtag_en_r <= 1'b0;
			dev_addr_r <= DFLT_DEV_ADDR;
		end
		else if (rst_hold_r)
		begin
			state_r <= B_CAPT;
			region_r <= '0;
			idx_r <= '0;
			sum_r <= '0;
			blank_r <= 1'b1;
			fw_ok_r <= 1'b0;
			dirty_r <= 1'b0;
		end
		else
		begin
			// set wins over a same-cycle clear
			if (alert_clr_in)
				crc_err_r <= 1'b0;
			unique case (state_r)
				B_CAPT:
				begin
					if (!pwrup_done_r)
						dev_addr_r <= strap_addr;
					state_r <= B_RD;
				end
				B_RD:
					state_r <= B_ACC;
				B_ACC:
				begin
					idx_r <= idx_r + ADDR_W'(1);
					state_r <= B_RD;
					if (!last)
					begin
						sum_r <= sum_r + dec_data;
						blank_r <= blank_r && (flash_rdata_in[DATA_W-1:0] == BLANK_WORD);
					end
					else
					begin
						idx_r <= '0;
						sum_r <= '0;
						blank_r <= 1'b1;
						region_r <= region_r + 2'd1;
						if (region_r == 2'd0)
							fw_ok_r <= sum_ok;
						else if (region_r == 2'd1)
						begin
							cfg_ok_r <= sum_ok;
							if (!sum_ok)
								crc_err_r <= 1'b1;
							if (!pwrup_done_r)
								jtag_en_r <= blank_r || (dev_addr_r == DFLT_DEV_ADDR);
							pwrup_done_r <= 1'b1;
						end
						else
						begin
							log_bad_r <= !sum_ok;
							state_r <= !cfg_ok_r ? B_DFLT : sum_ok ? B_RUN : B_ERASE;
						end
					end
				end
				B_DFLT:
				begin
					idx_r <= idx_r + ADDR_W'(1);
					if (idx_r == LAST_IDX - ADDR_W'(1))
					begin
						idx_r <= '0;
						state_r <= log_bad_r ? B_ERASE : B_RUN;
					end
				end
				B_ERASE:
					state_r <= B_EWAIT;
				B_EWAIT:
					if (!erase_log_r && !flash_busy_in)
						state_r <= B_RUN;
				B_RUN:
				begin
					if (store_all_in)
					begin
						state_r <= B_STORE;
						idx_r <= '0;
						sum_r <= '0;
					end
					// an image rewrite leaves RAM alone and stops logging until reset
					if (img_go || jtag_go || erase_go)
						dirty_r <= 1'b1;
				end
				B_STORE:
					if (store_go)
					begin
						idx_r <= idx_r + ADDR_W'(1);
						sum_r <= sum_r + wr_data;
						if (last)
						begin
							idx_r <= '0;
							state_r <= B_RUN;
						end
					end
			endcase
		end
	end

	// flash command outputs, registered
	always_ff @(posedge core_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			erase_r <= 1'b0;
			erase_log_r <= 1'b0;
			faddr_r <= '0;
			wdata_r <= '0;
			fix_r <= 1'b0;
		end
		else
		begin
			rd_r <= !rst_hold_r && (state_r == B_RD);
			wr_r <= !rst_hold_r && (store_go || jtag_go || img_go);
			erase_r <= !rst_hold_r && erase_go;
			erase_log_r <= !rst_hold_r && (state_r == B_ERASE);
			fix_r <= (state_r == B_ACC) && dec_err;
			if (state_r == B_RD)
				faddr_r <= base + idx_r;
			else if (store_go || jtag_go || img_go)
			begin
				faddr_r <= wr_addr;
				wdata_r <= {enc_chk, wr_data};
			end
		end
	end

	// config RAM and host parameter port
	always_ff @(posedge core_clk_in)
	begin
		if (ram_we)
			cfg_ram[ram_wa[$clog2(REGION_WORDS)-1:0]] <= ram_wd;
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			rd_data_r <= '0;
			reject_r <= 1'b0;
		end
		else
		begin
			rd_data_r <= (param_rd_idx_in < LAST_IDX) ? cfg_ram[param_rd_idx_in[$clog2(REGION_WORDS)-1:0]] : '0;
			reject_r <= param_wr_in && (!param_ok || !run);
		end
	end

	// test access port, clocked by sampled tck edges; no boundary register behind it
	assign tck_rise = jtag_en_r && shared_pin_in[0] && !tck_q_r;
	assign tck_fall = jtag_en_r && !shared_pin_in[0] && tck_q_r;
	assign tms = shared_pin_in[1];
	assign tdi = shared_pin_in[2];

	always_comb
	begin
		unique case (tap_r)
			T_TLR: tap_nxt = tms ? T_TLR : T_RTI;
			T_RTI: tap_nxt = tms ? T_SDS : T_RTI;
			T_SDS: tap_nxt = tms ? T_SIS : T_CDR;
			T_CDR: tap_nxt = tms ? T_E1D : T_SDR;
			T_SDR: tap_nxt = tms ? T_E1D : T_SDR;
			T_E1D: tap_nxt = tms ? T_UDR : T_PDR;
			T_PDR: tap_nxt = tms ? T_E2D : T_PDR;
			T_E2D: tap_nxt = tms ? T_UDR : T_SDR;
			T_UDR: tap_nxt = tms ? T_SDS : T_RTI;
			T_SIS: tap_nxt = tms ? T_TLR : T_CIR;
			T_CIR: tap_nxt = tms ? T_E1I : T_SIR;
			T_SIR: tap_nxt = tms ? T_E1I : T_SIR;
			T_E1I: tap_nxt = tms ? T_UIR : T_PIR;
			T_PIR: tap_nxt = tms ? T_E2I : T_PIR;
			T_E2I: tap_nxt = tms ? T_UIR : T_SIR;
			T_UIR: tap_nxt = tms ? T_SDS : T_RTI;
		endcase
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			tck_q_r <= 1'b0;
			tap_r <= T_TLR;
			ir_r <= IR_BYPASS;
			ir_sh_r <= '0;
			dr_sh_r <= '0;
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
			jtag_req_r <= 1'b0;
		end
		else
		begin
			tck_q_r <= shared_pin_in[0];
			if (jtag_go)
				jtag_req_r <= 1'b0;
			if (tck_rise)
			begin
				tap_r <= tap_nxt;
				unique case (tap_r)
					T_TLR: ir_r <= IR_BYPASS;
					T_CIR: ir_sh_r <= IR_CAPTURE;
					T_SIR: ir_sh_r <= {tdi, ir_sh_r[IR_W-1:1]};
					T_UIR: ir_r <= ir_sh_r;
					T_CDR: dr_sh_r <= '0;
					T_SDR: dr_sh_r <= (ir_r == IR_PROG) ? {tdi, dr_sh_r[DR_PROG_W-1:1]}
						: {dr_sh_r[DR_PROG_W-1:1], tdi};
					T_UDR: jtag_req_r <= (ir_r == IR_PROG);
					default: ;
				endcase
			end
			// tdo changes on the falling edge so the probe samples it stable
			if (tck_fall)
			begin
				tdo_r <= (tap_r == T_SIR) ? ir_sh_r[0] : dr_sh_r[0];
				tdo_oe_r <= (tap_r == T_SIR) || (tap_r == T_SDR);
			end
		end
	end

	// outputs
	assign flash_rd_out = rd_r;
	assign flash_wr_out = wr_r;
	assign flash_erase_out = erase_r;
	assign flash_erase_log_out = erase_log_r;
	assign flash_addr_out = faddr_r;
	assign flash_wdata_out = wdata_r;
	assign param_rd_data_out = rd_data_r;
	assign param_reject_out = reject_r;
	assign boot_done_out = run || (state_r == B_STORE);
	assign fw_run_out = boot_done_out && fw_ok_r;
	assign cfg_default_out = boot_done_out && !cfg_ok_r;
	assign cfg_crc_err_out = crc_err_r;
	assign bus_alert_out_n = !crc_err_r;
	assign log_corrupt_out = log_bad_r;
	assign log_en_out = boot_done_out && !dirty_r;
	assign jtag_en_out = jtag_en_r;
	assign ecc_fix_out = fix_r;
	assign in_reset_out = rst_hold_r;
	assign dev_addr_out = dev_addr_r;
	// pins released and pwm held low throughout any reset
	assign shared_pin_oe_out = rst_hold_r ? '0 : jtag_en_r ? {tdo_oe_r, 3'b000} : app_gpio_oe_in;
	assign shared_pin_out = rst_hold_r ? '0 : jtag_en_r ? {tdo_r, 3'b000} : app_gpio_out_in;
	assign fast_pulse_width_pin = rst_hold_r ? '0 : app_fast_pulse_width_pin_in;
endmodule

// *** tb/clic_top_properties.sv ***
// concurrent checks on the loader's ports
module clic_top_properties
	import clic_pkg::*;
#(
	parameter int REGION_WORDS = REGION_WORDS_DFLT,
	parameter int WDT_CYCLES = WDT_CYCLES_DFLT
)
(
	// clock, reset, host side
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic flash_wp_in,
	input wire logic img_erase_in,
	input wire logic img_wr_in,
	input wire logic [ADDR_W-1:0] img_addr_in,
	input wire logic [DATA_W-1:0] img_data_in,
	input wire logic param_wr_in,
	input wire logic [ADDR_W-1:0] param_idx_in,
	input wire logic [DATA_W-1:0] param_val_in,
	input wire logic wdt_kick_in,
	input wire logic [SHARED_PINS-1:0] app_gpio_out_in,
	input wire logic [SHARED_PINS-1:0] app_gpio_oe_in,
	input wire logic [FAST_PULSE_WIDTH_PIN_PINS-1:0] app_fast_pulse_width_pin_in,
	// design outputs
	input wire logic flash_wr_out,
	input wire logic flash_erase_out,
	input wire logic [ADDR_W-1:0] flash_addr_out,
	input wire logic [CW_W-1:0] flash_wdata_out,
	input wire logic img_ready_out,
	input wire logic param_reject_out,
	input wire logic boot_done_out,
	input wire logic fw_run_out,
	input wire logic cfg_crc_err_out,
	input wire logic bus_alert_out_n,
	input wire logic log_en_out,
	input wire logic jtag_en_out,
	input wire logic in_reset_out,
	input wire logic [DEV_ADDR_W-1:0] dev_addr_out,
	input wire logic [SHARED_PINS-1:0] shared_pin_out,
	input wire logic [SHARED_PINS-1:0] shared_pin_oe_out,
	input wire logic [FAST_PULSE_WIDTH_PIN_PINS-1:0] fast_pulse_width_pin
);
	int quiet_r;
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// cycles without a kick while firmware runs
	always_ff @(posedge core_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
			quiet_r <= 0;
		else if (wdt_kick_in || !fw_run_out)
			quiet_r <= 0;
		else
			quiet_r <= quiet_r + 1;
	AST_RST_QUIET: assert property (in_reset_out |-> fast_pulse_width_pin == '0 && shared_pin_oe_out == '0)
		else $error("pins active during reset hold");
	AST_FAST_PULSE_WIDTH_PIN_PASS: assert property (!in_reset_out |-> fast_pulse_width_pin == app_fast_pulse_width_pin_in)
		else $error("fast pwm pins not following the application");
	AST_GPIO_PASS: assert property (!jtag_en_out && !in_reset_out |-> shared_pin_out == app_gpio_out_in &&
		shared_pin_oe_out == app_gpio_oe_in)
		else $error("shared pins not serving as gpio");
	AST_TAP_INPUTS: assert property (jtag_en_out |-> shared_pin_oe_out[2:0] == 3'h0)
		else $error("test port inputs driven");
	AST_DFLT_JTAG: assert property (boot_done_out && dev_addr_out == DFLT_DEV_ADDR |-> jtag_en_out)
		else $error("default address without test port");
	AST_ALERT: assert property (bus_alert_out_n != cfg_crc_err_out)
		else $error("alert does not mirror checksum flag");
	AST_REJECT: assert property (param_wr_in && boot_done_out && (param_val_in > PARAM_MAX ||
		param_idx_in >= REGION_WORDS) |=> param_reject_out)
		else $error("out of range parameter taken");
	AST_IMG_WR: assert property (img_wr_in && img_ready_out |=> flash_wr_out &&
		flash_addr_out == $past(img_addr_in) && flash_wdata_out[31:0] == $past(img_data_in))
		else $error("image word not written");
	AST_WP: assert property (flash_wp_in |-> !img_ready_out)
		else $error("image write open while protected");
	AST_ERASE: assert property (img_erase_in && img_ready_out && boot_done_out && !img_wr_in |=>
		flash_erase_out ##1 !log_en_out)
		else $error("erase not done or logging left on");
	AST_WDT: assert property (quiet_r <= WDT_CYCLES + 4)
		else $error("watchdog did not fire");
endmodule

bind clic_top clic_top_properties #(.REGION_WORDS(REGION_WORDS), .WDT_CYCLES(WDT_CYCLES)) chk_u (.*);

// *** tb/clic_flash_model.sv ***
// behavioural data flash holding codewords, with read and busy timing
module clic_flash_model
	import clic_pkg::*;
#(
	parameter int BUSY_CYC = 3
)
(
	// clock and requests
	input wire logic clk_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic erase_in,
	input wire logic erase_log_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [CW_W-1:0] wdata_in,
	// answers
	output logic [CW_W-1:0] rdata_out,
	output logic busy_out
);
	logic [CW_W-1:0] mem [0:4095];
	logic [CW_W-1:0] idle_r = '0;
	int cnt = 0;
	function automatic logic [CHK_W-1:0] chk_of(input logic [DATA_W-1:0] d);
		logic [CHK_W-1:0] c;
		int i;
		c = '0;
		i = 0;
		for (int p = 3; p <= CW_W; p++)
			if ((p & (p - 1)) != 0)
			begin
				for (int k = 0; k < CHK_W; k++)
					c[k] = c[k] ^ (p[k] & d[i]);
				i++;
			end
		return c;
	endfunction
	task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		mem[a] = {chk_of(d), d};
	endtask
	task automatic blank();
		foreach (mem[i])
			mem[i] = '1;
	endtask
	assign busy_out = cnt != 0;
	// the loader takes the word in the cycle its read strobe stands
	assign rdata_out = rd_in ? mem[addr_in] : idle_r;
	always @(posedge clk_in)
	begin
		// a released data line toggles between the inverse of the last word and that word itself
		idle_r <= ~rdata_out;
		if (wr_in)
			mem[addr_in] <= wdata_in;
		if (erase_in || erase_log_in)
			for (int i = 0; i < 4096; i++)
				if (erase_in || (i >= 12'h200 && i < 12'h300))
					mem[i] <= '1;
		cnt <= (wr_in || erase_in || erase_log_in) ? BUSY_CYC : (cnt != 0 ? cnt - 1 : 0);
	end
endmodule

// *** tb/clic_top_tb_top.sv ***
// self-checking bench for the configuration loader
module clic_top_tb_top
	import clic_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in = 0, sys_rst_in = 1, addr_fault_in = 0;
	logic [3:0] addr_bin_hi_in = 4'h0, addr_bin_lo_in = 4'h0;
	logic flash_rd_out, flash_wr_out, flash_erase_out, flash_erase_log_out, flash_busy_in;
	logic [ADDR_W-1:0] flash_addr_out, img_addr_in = '0, param_idx_in = '0, param_rd_idx_in = '0;
	logic [CW_W-1:0] flash_wdata_out, flash_rdata_in;
	logic flash_wp_in = 0, img_erase_in = 0, img_wr_in = 0, img_ready_out, param_wr_in = 0;
	logic param_reject_out, store_all_in = 0, alert_clr_in = 0, wdt_kick_in = 1;
	logic [DATA_W-1:0] img_data_in = '0, param_val_in = '0, param_rd_data_out;
	logic boot_done_out, fw_run_out, cfg_default_out, cfg_crc_err_out, bus_alert_out_n;
	logic log_corrupt_out, log_en_out, jtag_en_out, ecc_fix_out, in_reset_out;
	logic [DEV_ADDR_W-1:0] dev_addr_out;
	logic [SHARED_PINS-1:0] shared_pin_in = '0, app_gpio_out_in = 4'ha, app_gpio_oe_in = 4'hc;
	logic [SHARED_PINS-1:0] shared_pin_out, shared_pin_oe_out;
	logic [FAST_PULSE_WIDTH_PIN_PINS-1:0] app_fast_pulse_width_pin_in = 8'h3c, fast_pulse_width_pin;
	int n_mismatch = 0, n_tests = 0, cyc = 0, n_fix = 0, n_elog = 0;
	// short watchdog so the timeout fits the run
	clic_top #(.WDT_CYCLES(50)) dut_u (.*);
	clic_flash_model flash_u (
		.clk_in(core_clk_in),
		.rd_in(flash_rd_out),
		.wr_in(flash_wr_out),
		.erase_in(flash_erase_out),
		.erase_log_in(flash_erase_log_out),
		.addr_in(flash_addr_out),
		.wdata_in(flash_wdata_out),
		.rdata_out(flash_rdata_in),
		.busy_out(flash_busy_in)
	);
	always #20 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in)
	begin
		cyc <= cyc + 1;
		// counts restart with every sys_rst_in pulse so each power-up is judged alone
		n_fix <= sys_rst_in ? 0 : n_fix + int'(ecc_fix_out === 1'b1);
		n_elog <= sys_rst_in ? 0 : n_elog + int'(flash_erase_log_out === 1'b1);
		if (cyc == 20000)
		begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk_in);
	endtask
	task automatic check(input logic [CW_W-1:0] seen, input logic [CW_W-1:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	function automatic logic sig(input int sel);
		return sel == 0 ? boot_done_out : sel == 1 ? in_reset_out : img_ready_out;
	endfunction
	task automatic wait_for(input int sel, input int lim);
		for (int i = 0; i < lim && sig(sel) !== 1'b1; i++)
			tick(1);
		check(sig(sel), 1'b1);
	endtask
	task automatic power_up(input logic [3:0] hi, input logic [3:0] lo, input logic flt);
		sys_rst_in = 1;
		addr_bin_hi_in = hi;
		addr_bin_lo_in = lo;
		addr_fault_in = flt;
		tick(4);
		sys_rst_in = 0;
		wait_for(0, 3000);
	endtask
	// one tck period; tms and tdi settle while tck is low
	task automatic tap(input logic ms, input logic di);
		shared_pin_in = {1'b0, di, ms, 1'b0};
		tick(1);
		shared_pin_in[0] = 1'b1;
		tick(1);
	endtask
	// program code into the instruction register, then one address/data word
	task automatic tap_prog(input logic [DR_PROG_W-1:0] w);
		logic [59:0] ms;
		ms = 60'h600_0000_0000_0b06;
		for (int i = 0; i < 60; i++)
			tap(ms[i], (i >= 5 && i < 9) ? IR_PROG[i-5] : (i >= 14 && i < 58) ? w[i-14] : 1'b0);
	endtask
	task automatic img_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		img_wr_in = 1;
		img_addr_in = a;
		img_data_in = d;
		wait_for(2, 50);
		tick(1);
		img_wr_in = 0;
		tick(1);
	endtask
	// three regions of 16 words plus a word-sum; bad bits spoil a sum
	task automatic load(input logic [DATA_W-1:0] s, input logic [2:0] bad, input bit bus);
		logic [DATA_W-1:0] sum;
		logic [DATA_W-1:0] d;
		for (int r = 0; r < 3; r++)
		begin
			sum = '0;
			for (int w = 0; w <= 16; w++)
			begin
				d = w == 16 ? sum + 32'(bad[r]) : s + 32'(r * 16 + w);
				sum += d;
				if (bus)
					img_wr(12'(r * 256 + w), d);
				else
					flash_u.put(12'(r * 256 + w), d);
			end
		end
	endtask
	task automatic param_wr(input logic [ADDR_W-1:0] i, input logic [DATA_W-1:0] v, input logic rej);
		param_wr_in = 1;
		param_idx_in = i;
		param_val_in = v;
		tick(1);
		param_wr_in = 0;
		check(param_reject_out, rej);
		tick(1);
	endtask
	task automatic param_rd(input logic [ADDR_W-1:0] i, input logic [DATA_W-1:0] e);
		param_rd_idx_in = i;
		tick(1);
		check(param_rd_data_out, e);
	endtask
	task automatic mem_is(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		check(flash_u.mem[a], {flash_u.chk_of(d), d});
	endtask
	initial
	begin
		load(32'h5, 3'h0, 0);
		flash_u.mem[12'h002] ^= 38'h80;
		power_up(4'h1, 4'h2, 1'b0);
		check(n_fix != 0, 1'b1);
		check(fw_run_out, 1'b1);
		check({cfg_default_out, bus_alert_out_n, log_corrupt_out, jtag_en_out, log_en_out}, 5'b01001);
		check(dev_addr_out, 7'd14);
		param_rd(12'h3, 32'h18);
		param_wr(12'h3, 32'h1234, 1'b0);
		param_wr(12'h4, 32'h10000, 1'b1);
		param_wr(12'h10, 32'h1, 1'b1);
		param_rd(12'h3, 32'h1234);
		param_rd(12'h4, 32'h19);
		mem_is(12'h103, 32'h18);
		store_all_in = 1;
		tick(1);
		store_all_in = 0;
		tick(300);
		mem_is(12'h103, 32'h1234);
		mem_is(12'h110, 32'h13e4);
		flash_wp_in = 1;
		tick(1);
		check(img_ready_out, 1'b0);
		flash_wp_in = 0;
		img_erase_in = 1;
		tick(1);
		img_erase_in = 0;
		tick(20);
		check(log_en_out, 1'b0);
		param_rd(12'h3, 32'h1234);
		load(32'h40, 3'h0, 1);
		mem_is(12'h105, 32'h55);
		power_up(4'h1, 4'h2, 1'b0);
		param_rd(12'h5, 32'h55);
		check(log_en_out, 1'b1);
		load(32'h9, 3'h7, 0);
		power_up(4'h3, 4'h4, 1'b0);
		check({fw_run_out, cfg_default_out, cfg_crc_err_out, bus_alert_out_n, log_corrupt_out}, 5'b01101);
		check(n_elog != 0, 1'b1);
		param_rd(12'h3, CFG_DFLT_VAL);
		alert_clr_in = 1;
		tick(1);
		alert_clr_in = 0;
		tick(1);
		check(bus_alert_out_n, 1'b1);
		load(32'h5, 3'h0, 0);
		power_up(4'h1, 4'h2, 1'b1);
		check({dev_addr_out, jtag_en_out}, {DFLT_DEV_ADDR, 1'b1});
		tap_prog({12'h0a0, 32'h600d});
		tick(5);
		mem_is(12'h0a0, 32'h600d);
		power_up(4'ha, 4'h6, 1'b0);
		check({dev_addr_out, jtag_en_out}, {DFLT_DEV_ADDR, 1'b1});
		flash_u.blank();
		power_up(4'h1, 4'h2, 1'b0);
		check({jtag_en_out, cfg_default_out}, 2'b11);
		load(32'h5, 3'h0, 0);
		power_up(4'h1, 4'h2, 1'b0);
		check(fast_pulse_width_pin, 8'h3c);
		wdt_kick_in = 0;
		wait_for(1, 200);
		check({fast_pulse_width_pin, shared_pin_oe_out}, 12'h0);
		wdt_kick_in = 1;
		wait_for(0, 3000);
		check(dev_addr_out, 7'd14);
		finish_test();
	end
endmodule
